// ---- hw/sbk_defs.svh ----
// Purpose: constants for the supply-check and buck1 control bank
// Assumes: 16-bit registers on a plain address/strobe port
// Notes: offsets are register indices on the port
`ifndef SBK_DEFS_SVH
`define SBK_DEFS_SVH
`define SBK_ADDR_W 8
`define SBK_OFF_SUPPLY_CFG 8'hB3
`define SBK_OFF_BUCK1_CTRL 8'hB4
`define SBK_OFF_BUCK1_TMO 8'hB5
`define SBK_OFF_IRQ_STATUS 8'hC0
`define SBK_OFF_IRQ_MASK 8'hC1
`define SBK_OFF_KEY 8'hC2
`define SBK_KEY_VALUE 16'hA5C3
`define SBK_LOW_ACT_BIT 14
`define SBK_HIB_USE_BIT 12
`define SBK_OFF_THR_HI 6
`define SBK_OFF_THR_LO 4
`define SBK_ON_THR_HI 2
`define SBK_ON_THR_LO 0
`define SBK_CAP_HI 15
`define SBK_CAP_LO 14
`define SBK_FLOAT_BIT 10
`define SBK_VSEL_HI 6
`define SBK_VSEL_LO 0
`define SBK_FACT_HI 15
`define SBK_FACT_LO 14
`define SBK_SLOT_HI 13
`define SBK_SLOT_LO 10
`define SBK_SUPPLY_CFG_RST 16'h0025
`define SBK_BUCK1_CTRL_RST 16'h000E
`define SBK_BUCK1_TMO_RST 16'h0000
`define SBK_SUPPLY_CFG_WMASK 16'h5077
`define SBK_BUCK1_CTRL_WMASK 16'hCC7F
`define SBK_BUCK1_TMO_WMASK 16'hFC00
`define SBK_THR_WMASK 16'h0077
`define SBK_VSEL_MAX 7'h66
`define SBK_THR_BASE_MV 2900
`define SBK_THR_STEP_MV 100
`define SBK_VOUT_BASE_MV 850
`define SBK_VOUT_STEP_MV 25
`endif

// ---- hw/sbk_pkg.sv ----
// Purpose: types for the supply-check and buck1 control bank
// Assumes: constants live in sbk_defs.svh
// Notes: none
package sbk_pkg;
    typedef enum logic [2:0] {
        SBK_RUN = 3'h1,
        SBK_UNLOCKED = 3'h2,
        SBK_TRIPPED = 3'h4
    } sbk_state_t;
    typedef enum logic [1:0] {
        SBK_FA_IGNORE = 2'h0,
        SBK_FA_CONV = 2'h1,
        SBK_FA_SYS = 2'h2,
        SBK_FA_SYS_RSV = 2'h3
    } sbk_fault_act_t;
endpackage : sbk_pkg

// ---- hw/sbk_sync.sv ----
// Purpose: two-flop synchroniser for one level
// Assumes: input is asynchronous to sys_clk_i
// Notes: first stage is read only by the second
`timescale 1ns/1ns
`default_nettype none
module sbk_sync (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Level
    input wire logic async_i,
    output logic sync_o
);
    logic [1:0] stage;
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stage <= 2'h0;
        end else begin
            stage <= {stage[0], async_i};
        end
    end
    assign sync_o = stage[1];
endmodule : sbk_sync
`default_nettype wire

// ---- hw/sbk_bank.sv ----
// Purpose: supply-check comparator and buck1 control registers
// Assumes: comparator and fault inputs arrive from analogue, asynchronous
// Notes: state-machine reset returns fields to their fixed defaults
`timescale 1ns/1ns
`default_nettype none
`include "sbk_defs.svh"

// Behaviour
// - Supply below turn-off raises the critical interrupt, and a hard shutdown too when bit 14 is set.
// - Bit 12 keeps the comparator on in hibernate when 1 and unused there when 0.
// - The turn-off threshold is bits 6:4, default 010, 000 is 2.9V up to 111 at 3.6V.
// - The turn-on threshold is bits 2:0, default 101, same encoding as turn-off.
// - Threshold writes are ignored unless the security key has been written first.
// - Bits 15:14 of buck1 control select the output capacitor range, code 10 unused.
// - Bit 10 of buck1 control discharges the output on disable when 0, floats it when 1.
// - The voltage code is bits 6:0 in 25mV steps from 0.85V, topping at 3.4V at 1100110.
// - A buck1 fault always interrupts; bits 15:14 add nothing, converter or system shutdown.
// - Bits 13:10 pick the start slot: 0000 off, 1 to 14 slots, 1111 on entering active.
// - A state-machine reset returns the control and timeout fields to fixed defaults.
module sbk_bank
    import sbk_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic sm_reset_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    // Analogue status
    input wire logic supply_low_i,
    input wire logic buck1_fault_i,
    input wire logic hibernate_i,
    // Controls to analogue and sequencer
    output logic comparator_enable_o,
    output logic [2:0] turn_off_threshold_o,
    output logic [2:0] turn_on_threshold_o,
    output logic [11:0] turn_off_mv_o,
    output logic [11:0] turn_on_mv_o,
    output logic [1:0] buck1_cap_range_o,
    output logic buck1_discharge_o,
    output logic [6:0] buck1_voltage_code_o,
    output logic [11:0] buck1_target_mv_o,
    output logic [3:0] buck1_startup_slot_o,
    output logic buck1_never_start_o,
    output logic buck1_start_on_active_o,
    output logic hard_shutdown_o,
    output logic buck1_shutdown_o,
    // Interrupt
    output logic irq_o
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        sbk_state_t fsm;
        logic [15:0] supply_cfg;
        logic [15:0] ctrl;
        logic [15:0] tmo;
        logic [1:0] status;
        logic [1:0] mask;
        logic low_d;
        logic fault_d;
        logic hard_sd;
        logic conv_sd;
        logic [15:0] rdata;
    } sbk_regs_t;

    sbk_regs_t r;
    sbk_regs_t next_r;
    logic low_s;
    logic fault_s;

    // ----------------------------------------------------------------
    // Synchronisers
    // ----------------------------------------------------------------
    sbk_sync u_low_sync (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .async_i(supply_low_i),
        .sync_o(low_s)
    );
    sbk_sync u_fault_sync (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .async_i(buck1_fault_i),
        .sync_o(fault_s)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic low_rise;
    logic fault_rise;
    logic comp_on;
    logic [15:0] wmask;
    assign comp_on = !hibernate_i || r.supply_cfg[`SBK_HIB_USE_BIT];
    // Masking the edge when the comparator is off avoids a spurious trip in hibernate
    assign low_rise = low_s && !r.low_d && comp_on;
    assign fault_rise = fault_s && !r.fault_d;

    always_comb begin
        next_r = r;
        next_r.low_d = low_s;
        next_r.fault_d = fault_s;
        next_r.rdata = 16'h0000;
        wmask = `SBK_SUPPLY_CFG_WMASK;
        // Key is single-use: the next register write of any kind re-locks, reads do not
        if (r.fsm != SBK_UNLOCKED) begin
            wmask = `SBK_SUPPLY_CFG_WMASK & ~`SBK_THR_WMASK;
        end
        if (reg_wr_i) begin
            case (reg_addr_i)
                `SBK_OFF_SUPPLY_CFG: begin
                    next_r.supply_cfg = (r.supply_cfg & ~wmask) | (reg_wdata_i & wmask);
                end
                `SBK_OFF_BUCK1_CTRL: begin
                    next_r.ctrl = reg_wdata_i & `SBK_BUCK1_CTRL_WMASK;
                    if (reg_wdata_i[`SBK_VSEL_HI:`SBK_VSEL_LO] > `SBK_VSEL_MAX) begin
                        next_r.ctrl[`SBK_VSEL_HI:`SBK_VSEL_LO] = `SBK_VSEL_MAX;
                    end
                end
                `SBK_OFF_BUCK1_TMO: begin
                    next_r.tmo = reg_wdata_i & `SBK_BUCK1_TMO_WMASK;
                end
                `SBK_OFF_IRQ_STATUS: begin
                    next_r.status = r.status & ~reg_wdata_i[1:0];
                end
                `SBK_OFF_IRQ_MASK: begin
                    next_r.mask = reg_wdata_i[1:0];
                end
                default: begin
                end
            endcase
        end
        // State machine: key unlocks one following threshold write
        case (r.fsm)
            SBK_RUN: begin
                if (reg_wr_i && reg_addr_i == `SBK_OFF_KEY
                    && reg_wdata_i == `SBK_KEY_VALUE) begin
                    next_r.fsm = SBK_UNLOCKED;
                end
            end
            SBK_UNLOCKED: begin
                if (reg_wr_i) begin
                    next_r.fsm = SBK_RUN;
                end
            end
            SBK_TRIPPED: begin
                // Hard shutdown holds until the power state machine resets
            end
            default: begin
                next_r.fsm = SBK_RUN;
            end
        endcase
        // Events set after clear so a simultaneous event wins
        if (low_rise) begin
            next_r.status[0] = 1'b1;
            if (r.supply_cfg[`SBK_LOW_ACT_BIT]) begin
                next_r.hard_sd = 1'b1;
                next_r.fsm = SBK_TRIPPED;
            end
        end
        if (fault_rise) begin
            next_r.status[1] = 1'b1;
            case (sbk_fault_act_t'(r.tmo[`SBK_FACT_HI:`SBK_FACT_LO]))
                SBK_FA_IGNORE: begin
                end
                SBK_FA_CONV: begin
                    next_r.conv_sd = 1'b1;
                end
                default: begin
                    next_r.hard_sd = 1'b1;
                    next_r.fsm = SBK_TRIPPED;
                end
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                `SBK_OFF_SUPPLY_CFG: next_r.rdata = r.supply_cfg;
                `SBK_OFF_BUCK1_CTRL: next_r.rdata = r.ctrl;
                `SBK_OFF_BUCK1_TMO: next_r.rdata = r.tmo;
                `SBK_OFF_IRQ_STATUS: next_r.rdata = {14'h0000, r.status};
                `SBK_OFF_IRQ_MASK: next_r.rdata = {14'h0000, r.mask};
                `SBK_OFF_KEY: next_r.rdata = {15'h0000, r.fsm == SBK_UNLOCKED};
                default: next_r.rdata = 16'h0000;
            endcase
        end
        if (sm_reset_i) begin
            next_r.supply_cfg = `SBK_SUPPLY_CFG_RST;
            next_r.ctrl = `SBK_BUCK1_CTRL_RST;
            next_r.tmo = `SBK_BUCK1_TMO_RST;
            next_r.hard_sd = 1'b0;
            next_r.conv_sd = 1'b0;
            next_r.fsm = SBK_RUN;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r <= '{fsm: SBK_RUN, supply_cfg: `SBK_SUPPLY_CFG_RST,
                   ctrl: `SBK_BUCK1_CTRL_RST, tmo: `SBK_BUCK1_TMO_RST,
                   status: 2'h0, mask: 2'h0, low_d: 1'b0, fault_d: 1'b0,
                   hard_sd: 1'b0, conv_sd: 1'b0, rdata: 16'h0000};
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata_o = r.rdata;
    assign comparator_enable_o = comp_on;
    assign turn_off_threshold_o = r.supply_cfg[`SBK_OFF_THR_HI:`SBK_OFF_THR_LO];
    assign turn_on_threshold_o = r.supply_cfg[`SBK_ON_THR_HI:`SBK_ON_THR_LO];
    assign turn_off_mv_o = 12'(`SBK_THR_BASE_MV + `SBK_THR_STEP_MV * turn_off_threshold_o);
    assign turn_on_mv_o = 12'(`SBK_THR_BASE_MV + `SBK_THR_STEP_MV * turn_on_threshold_o);
    assign buck1_cap_range_o = r.ctrl[`SBK_CAP_HI:`SBK_CAP_LO];
    assign buck1_discharge_o = !r.ctrl[`SBK_FLOAT_BIT];
    assign buck1_voltage_code_o = r.ctrl[`SBK_VSEL_HI:`SBK_VSEL_LO];
    assign buck1_target_mv_o = 12'(`SBK_VOUT_BASE_MV
                                   + `SBK_VOUT_STEP_MV * buck1_voltage_code_o);
    assign buck1_startup_slot_o = r.tmo[`SBK_SLOT_HI:`SBK_SLOT_LO];
    assign buck1_never_start_o = buck1_startup_slot_o == 4'h0;
    assign buck1_start_on_active_o = buck1_startup_slot_o == 4'hF;
    assign hard_shutdown_o = r.hard_sd;
    assign buck1_shutdown_o = r.conv_sd;
    assign irq_o = |(r.status & r.mask);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence low_edge_s;
        low_rise;
    endsequence
    sequence trip_s;
        ##1 (r.status[0] && hard_shutdown_o);
    endsequence
    // A trip in the same cycle as the key also counts, since it outranks the unlock
    sequence unlock_s;
        ##1 (r.fsm == SBK_UNLOCKED || hard_shutdown_o);
    endsequence

    low_trip_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (low_edge_s and (r.supply_cfg[`SBK_LOW_ACT_BIT] && !sm_reset_i)) |-> trip_s)
        else $error("low supply did not trip shutdown");
    low_only_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        low_rise && !r.supply_cfg[`SBK_LOW_ACT_BIT] && !r.hard_sd && !fault_rise
        |=> r.status[0] && !hard_shutdown_o)
        else $error("interrupt-only action shut down");
    hib_use_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        hibernate_i && !r.supply_cfg[`SBK_HIB_USE_BIT] |-> !comparator_enable_o)
        else $error("comparator active in hibernate");
    thr_lock_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        reg_wr_i && reg_addr_i == `SBK_OFF_SUPPLY_CFG && r.fsm != SBK_UNLOCKED && !sm_reset_i
        |=> $stable(turn_off_threshold_o) && $stable(turn_on_threshold_o))
        else $error("locked threshold changed");
    thr_mv_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        turn_off_threshold_o == 3'h7 |-> turn_off_mv_o == 12'd3600)
        else $error("threshold ladder wrong");
    vsel_max_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        buck1_voltage_code_o <= `SBK_VSEL_MAX && buck1_target_mv_o <= 12'd3400)
        else $error("voltage code above maximum");
    float_bit_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        buck1_discharge_o != r.ctrl[`SBK_FLOAT_BIT])
        else $error("discharge polarity wrong");
    fault_conv_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        fault_rise && r.tmo[15:14] == 2'h1 && !sm_reset_i |=> buck1_shutdown_o && r.status[1])
        else $error("converter fault action missed");
    fault_ign_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        fault_rise && r.tmo[15:14] == 2'h0 && !r.hard_sd && !r.conv_sd && !low_rise
        |=> r.status[1] && !buck1_shutdown_o && !hard_shutdown_o)
        else $error("ignore action took action");
    sm_rst_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        sm_reset_i |=> r.ctrl == `SBK_BUCK1_CTRL_RST && r.tmo == `SBK_BUCK1_TMO_RST
        && r.supply_cfg == `SBK_SUPPLY_CFG_RST)
        else $error("state-machine reset missed defaults");
    sync_low_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        r.status[0] && !$past(r.status[0]) |-> $past(low_s))
        else $error("interrupt set without synchronised level");
    slot_act_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        buck1_start_on_active_o |-> !buck1_never_start_o && r.tmo[13:10] == 4'hF)
        else $error("start slot decode wrong");

    low_set_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        low_rise |=> r.status[0])
        else $error("low supply event lost");
    low_clear_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        reg_wr_i && reg_addr_i == `SBK_OFF_IRQ_STATUS && reg_wdata_i[0]
        && !low_rise |=> !r.status[0])
        else $error("low supply status not cleared");
    hard_hold_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        r.hard_sd && !sm_reset_i |=> hard_shutdown_o)
        else $error("hard shutdown released early");
    fault_set_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        fault_rise |=> r.status[1])
        else $error("fault interrupt lost");
    fault_sys_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        fault_rise && r.tmo[`SBK_FACT_HI] && !sm_reset_i |=> hard_shutdown_o)
        else $error("system fault action missed");
    hib_ignore_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        low_s && !r.low_d && hibernate_i && !r.supply_cfg[`SBK_HIB_USE_BIT]
        && !r.status[0] |=> !r.status[0])
        else $error("low supply seen in hibernate");
    key_unlock_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        r.fsm == SBK_RUN && reg_wr_i && reg_addr_i == `SBK_OFF_KEY
        && reg_wdata_i == `SBK_KEY_VALUE && !sm_reset_i |-> unlock_s)
        else $error("key did not unlock");
    key_relock_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        r.fsm == SBK_UNLOCKED && reg_wr_i |=> r.fsm != SBK_UNLOCKED)
        else $error("key used twice");
    thr_write_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        r.fsm == SBK_UNLOCKED && reg_wr_i && reg_addr_i == `SBK_OFF_SUPPLY_CFG && !sm_reset_i
        |=> turn_off_threshold_o == $past(reg_wdata_i[`SBK_OFF_THR_HI:`SBK_OFF_THR_LO])
        && turn_on_threshold_o == $past(reg_wdata_i[`SBK_ON_THR_HI:`SBK_ON_THR_LO]))
        else $error("unlocked threshold write lost");
    cap_write_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        reg_wr_i && reg_addr_i == `SBK_OFF_BUCK1_CTRL && !sm_reset_i
        |=> buck1_cap_range_o == $past(reg_wdata_i[`SBK_CAP_HI:`SBK_CAP_LO]))
        else $error("capacitor range not stored");
    float_write_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        reg_wr_i && reg_addr_i == `SBK_OFF_BUCK1_CTRL && !sm_reset_i
        |=> buck1_discharge_o == !$past(reg_wdata_i[`SBK_FLOAT_BIT]))
        else $error("discharge control not stored");
    vsel_write_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        reg_wr_i && reg_addr_i == `SBK_OFF_BUCK1_CTRL && !sm_reset_i
        && reg_wdata_i[`SBK_VSEL_HI:`SBK_VSEL_LO] <= `SBK_VSEL_MAX
        |=> buck1_voltage_code_o == $past(reg_wdata_i[`SBK_VSEL_HI:`SBK_VSEL_LO]))
        else $error("voltage code not stored");
    slot_write_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        reg_wr_i && reg_addr_i == `SBK_OFF_BUCK1_TMO && !sm_reset_i
        |=> buck1_startup_slot_o == $past(reg_wdata_i[`SBK_SLOT_HI:`SBK_SLOT_LO]))
        else $error("start slot not stored");
    sync_delay_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        $rose(low_s) |-> $past(supply_low_i, 2))
        else $error("low supply bypassed synchroniser");
    sm_clear_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        sm_reset_i |=> !hard_shutdown_o && !buck1_shutdown_o)
        else $error("state-machine reset left a shutdown");
endmodule : sbk_bank
`default_nettype wire

// ---- bench/sbk_bank_tb.sv ----
// Purpose: self-checking bench for the supply-check and buck1 control bank
// Assumes: register port with one-cycle strobes, read data one cycle later
// Notes: reads queue their expectation; a monitor compares when data appears
`timescale 1ns/1ns
`default_nettype none
`include "sbk_defs.svh"
module sbk_bank_tb
    import sbk_pkg::*;
;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic sm_reset_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic supply_low_i = 1'b0;
    logic buck1_fault_i = 1'b0;
    logic hibernate_i = 1'b0;
    logic [15:0] reg_rdata_o;
    logic comparator_enable_o, buck1_discharge_o, buck1_never_start_o;
    logic buck1_start_on_active_o, hard_shutdown_o, buck1_shutdown_o, irq_o;
    logic [2:0] turn_off_threshold_o, turn_on_threshold_o;
    logic [11:0] turn_off_mv_o, turn_on_mv_o, buck1_target_mv_o;
    logic [1:0] buck1_cap_range_o;
    logic [6:0] buck1_voltage_code_o;
    logic [3:0] buck1_startup_slot_o;
    logic rd_d = 1'b0;
    logic [15:0] exp_q[$];
    logic [15:0] d;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed;

    sbk_bank dut (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .sm_reset_i(sm_reset_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .supply_low_i(supply_low_i),
        .buck1_fault_i(buck1_fault_i), .hibernate_i(hibernate_i),
        .comparator_enable_o(comparator_enable_o),
        .turn_off_threshold_o(turn_off_threshold_o),
        .turn_on_threshold_o(turn_on_threshold_o), .turn_off_mv_o(turn_off_mv_o),
        .turn_on_mv_o(turn_on_mv_o), .buck1_cap_range_o(buck1_cap_range_o),
        .buck1_discharge_o(buck1_discharge_o),
        .buck1_voltage_code_o(buck1_voltage_code_o),
        .buck1_target_mv_o(buck1_target_mv_o),
        .buck1_startup_slot_o(buck1_startup_slot_o),
        .buck1_never_start_o(buck1_never_start_o),
        .buck1_start_on_active_o(buck1_start_on_active_o),
        .hard_shutdown_o(hard_shutdown_o), .buck1_shutdown_o(buck1_shutdown_o),
        .irq_o(irq_o)
    );

    // ------------------------------
    // Clock, timeout, report
    // ------------------------------
    initial begin
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    // Bounded well above the roughly 240 cycles the sequence needs
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 8000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Read data stands only in the cycle after the strobe
    always @(posedge sys_clk_i) begin
        rd_d <= reg_rd_i;
        if (rd_d) begin
            chk("read data", reg_rdata_o, exp_q.pop_front());
        end
    end

    // ------------------------------
    // Register port and stimulus tasks
    // ------------------------------
    // Strobe drops after one edge; ending on the falling edge keeps checks off the race
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        @(negedge sys_clk_i);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] v);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        exp_q.push_back(v);
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge sys_clk_i);
    endtask : rd

    // Held for several cycles so the two-flop synchroniser sees it
    task automatic ev(input bit fault);
        @(posedge sys_clk_i);
        if (fault) begin
            buck1_fault_i <= 1'b1;
        end else begin
            supply_low_i <= 1'b1;
        end
        repeat (5) @(posedge sys_clk_i);
        buck1_fault_i <= 1'b0;
        supply_low_i <= 1'b0;
        repeat (2) @(negedge sys_clk_i);
    endtask : ev

    task automatic smr();
        @(posedge sys_clk_i);
        sm_reset_i <= 1'b1;
        @(posedge sys_clk_i);
        sm_reset_i <= 1'b0;
        @(negedge sys_clk_i);
    endtask : smr

    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        seed = $urandom(85247);
        repeat (3) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        rd(`SBK_OFF_SUPPLY_CFG, 16'h0025);
        rd(`SBK_OFF_BUCK1_CTRL, 16'h000E);
        rd(`SBK_OFF_BUCK1_TMO, 16'h0000);
        chk("off mv", 16'(turn_off_mv_o), 16'd3100);
        chk("on mv", 16'(turn_on_mv_o), 16'd3400);
        wr(`SBK_OFF_SUPPLY_CFG, 16'h5077);
        rd(`SBK_OFF_SUPPLY_CFG, 16'h5025);
        wr(8'h10, 16'hFFFF);
        rd(8'h10, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            wr(`SBK_OFF_KEY, `SBK_KEY_VALUE);
            wr(`SBK_OFF_SUPPLY_CFG, 16'((i << 4) | (7 - i)));
            chk("off code", 16'(turn_off_threshold_o), 16'(i));
            chk("on code", 16'(turn_on_threshold_o), 16'(7 - i));
            chk("off mv", 16'(turn_off_mv_o), 16'(2900 + 100 * i));
            chk("on mv", 16'(turn_on_mv_o), 16'(2900 + 100 * (7 - i)));
        end
        for (int i = 0; i < 8; i++) begin
            d = 16'(((i % 4) << 14) | (($urandom % 2) << 10) | ($urandom % 103));
            wr(`SBK_OFF_BUCK1_CTRL, d);
            rd(`SBK_OFF_BUCK1_CTRL, d);
            chk("cap", 16'(buck1_cap_range_o), 16'(d[15:14]));
            chk("discharge", 16'(buck1_discharge_o), 16'(!d[10]));
            chk("target mv", 16'(buck1_target_mv_o), 16'(850 + 25 * d[6:0]));
            chk("vsel", 16'(buck1_voltage_code_o), 16'(d[6:0]));
        end
        wr(`SBK_OFF_BUCK1_CTRL, 16'h007F);
        rd(`SBK_OFF_BUCK1_CTRL, 16'h0066);
        chk("vsel", 16'(buck1_voltage_code_o), 16'h0066);
        chk("target mv", 16'(buck1_target_mv_o), 16'd3400);
        for (int s = 0; s < 16; s++) begin
            wr(`SBK_OFF_BUCK1_TMO, 16'(s << 10));
            chk("slot", 16'(buck1_startup_slot_o), 16'(s));
            chk("never", 16'(buck1_never_start_o), 16'(s == 0));
            chk("on active", 16'(buck1_start_on_active_o), 16'(s == 15));
        end
        wr(`SBK_OFF_SUPPLY_CFG, 16'h0000);
        wr(`SBK_OFF_IRQ_MASK, 16'h0003);
        @(posedge sys_clk_i);
        hibernate_i <= 1'b1;
        ev(0);
        chk("cmp enable", 16'(comparator_enable_o), 16'h0000);
        rd(`SBK_OFF_IRQ_STATUS, 16'h0000);
        wr(`SBK_OFF_SUPPLY_CFG, 16'h1000);
        chk("cmp enable", 16'(comparator_enable_o), 16'h0001);
        // Still in hibernate: the kept-on comparator must raise the event
        ev(0);
        rd(`SBK_OFF_IRQ_STATUS, 16'h0001);
        chk("irq", 16'(irq_o), 16'h0001);
        chk("hard", 16'(hard_shutdown_o), 16'h0000);
        @(posedge sys_clk_i);
        hibernate_i <= 1'b0;
        wr(`SBK_OFF_IRQ_STATUS, 16'h0001);
        chk("irq", 16'(irq_o), 16'h0000);
        wr(`SBK_OFF_IRQ_MASK, 16'h0000);
        ev(0);
        chk("irq", 16'(irq_o), 16'h0000);
        wr(`SBK_OFF_IRQ_STATUS, 16'h0003);
        wr(`SBK_OFF_IRQ_MASK, 16'h0003);
        wr(`SBK_OFF_SUPPLY_CFG, 16'h4000);
        ev(0);
        chk("hard", 16'(hard_shutdown_o), 16'h0001);
        smr();
        chk("hard", 16'(hard_shutdown_o), 16'h0000);
        rd(`SBK_OFF_SUPPLY_CFG, 16'h0025);
        rd(`SBK_OFF_BUCK1_CTRL, 16'h000E);
        wr(`SBK_OFF_IRQ_STATUS, 16'h0003);
        for (int a = 0; a < 4; a++) begin
            wr(`SBK_OFF_BUCK1_TMO, 16'(a << 14));
            ev(1);
            rd(`SBK_OFF_IRQ_STATUS, 16'h0002);
            chk("irq", 16'(irq_o), 16'h0001);
            chk("conv off", 16'(buck1_shutdown_o), 16'(a == 1));
            chk("hard", 16'(hard_shutdown_o), 16'(a >= 2));
            smr();
            wr(`SBK_OFF_IRQ_STATUS, 16'h0003);
        end
        repeat (3) @(posedge sys_clk_i);
        end_of_test();
    end
endmodule : sbk_bank_tb
`default_nettype wire
